/* File: core/bit_branch_exec_defines.vh */
// Opcode, operand-kind, length and cycle-cost constants of the exec unit
`ifndef BIT_BRANCH_EXEC_DEFINES_VH
`define BIT_BRANCH_EXEC_DEFINES_VH

// Operation classes on op_code
`define OP_BRANCH_IF_BIT_SET      4'h0
`define OP_BRANCH_IF_BIT_CLEAR    4'h1
`define OP_TEST_BRANCH_AND_CLEAR  4'h2
`define OP_DECREMENT_BRANCH_NZ    4'h3
`define OP_BANK_SELECT            4'h4
`define OP_IDLE_INSTR             4'h5
`define OP_IRQ_ENABLE             4'h6
`define OP_IRQ_MASK               4'h7
`define OP_HALT                   4'h8
`define OP_STANDBY                4'h9

// Operand kinds on operand_kind, also the write-back target code
`define KIND_SADDR                3'h0
`define KIND_SFR                  3'h1
`define KIND_ACC                  3'h2
`define KIND_STATUS_WORD          3'h3
`define KIND_POINTER              3'h4
`define KIND_REG_B                3'h5
`define KIND_REG_C                3'h6

// Instruction lengths in bytes
`define LEN_1                     3'h1
`define LEN_2                     3'h2
`define LEN_3                     3'h3
`define LEN_4                     3'h4

// Cycle costs: first figure internal high-speed RAM, second other area
`define CYC_2                     6'h02
`define CYC_4                     6'h04
`define CYC_6                     6'h06
`define CYC_8                     6'h08
`define CYC_9                     6'h09
`define CYC_10                    6'h0A
`define CYC_11                    6'h0B
`define CYC_12                    6'h0C

`endif

/* File: core/exec_cycle_timer.v */
// Down-counter that holds the unit busy for a given number of clocks
`timescale 1ns/1ns
`default_nettype none
module exec_cycle_timer (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       load,
  input  wire [5:0] cycles,
  output reg        busy,
  output wire       expire
);
  reg [5:0] remain;

  // Last busy clock of the instruction
  assign expire = busy && (remain == 6'h01);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      remain <= 6'h00;
      busy   <= 1'b0;
    end else if (load) begin
      remain <= cycles;
      busy   <= (cycles != 6'h00);
    end else if (busy) begin
      remain <= remain - 6'h01;
      busy   <= (remain != 6'h01);
    end
  end
endmodule
`default_nettype wire

/* File: core/bit_branch_eval.v */
// Bit test, loop decrement, write-back data and branch target arithmetic
`timescale 1ns/1ns
`default_nettype none
`include "bit_branch_exec_defines.vh"
module bit_branch_eval (
  input  wire [3:0]  op_code,
  input  wire [2:0]  bit_sel,
  input  wire [7:0]  operand_byte,
  input  wire [7:0]  rel_offset8,
  input  wire [15:0] pc_in,
  input  wire [2:0]  instr_length,
  output reg         branch_taken,
  output reg         write_back,
  output reg  [7:0]  write_data,
  output wire [15:0] fall_through_pc,
  output wire [15:0] branch_target_pc
);
  wire       tested_bit;
  wire [7:0] decremented;

  function [15:0] pc_plus;
    input [15:0] base;
    input [15:0] delta;
    begin
      pc_plus = base + delta;
    end
  endfunction

  assign tested_bit  = operand_byte[bit_sel];
  assign decremented = operand_byte - 8'h01;
  assign fall_through_pc = pc_plus(pc_in, {13'h0000, instr_length});
  // RL20 signed displacement add
  assign branch_target_pc = pc_plus(fall_through_pc,
                                    {{8{rel_offset8[7]}}, rel_offset8});

  always @* begin
    branch_taken = 1'b0;
    write_back   = 1'b0;
    write_data   = operand_byte;
    case (op_code)
      `OP_BRANCH_IF_BIT_SET: begin
        branch_taken = tested_bit;
      end
      `OP_BRANCH_IF_BIT_CLEAR: begin
        branch_taken = !tested_bit;
      end
      `OP_TEST_BRANCH_AND_CLEAR: begin
        // RL11 clear only when set
        branch_taken = tested_bit;
        write_back   = tested_bit;
        write_data   = operand_byte & ~(8'h01 << bit_sel);
      end
      `OP_DECREMENT_BRANCH_NZ: begin
        // RL16 decrement before test
        write_back   = 1'b1;
        write_data   = decremented;
        branch_taken = (decremented != 8'h00);
      end
      default: begin
        branch_taken = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: core/bit_branch_cpu_control_exec.v */
// Execution of bit branches, loop branches and CPU control operations
//
// Behaviour
// RL1 - One instruction clock equals one sys_clk period.
// RL2 - First cost for high-speed RAM or no data, second otherwise.
// RL3 - Set-test on short direct bit: 3 bytes, 8/9 clocks, PC+3+disp.
// RL4 - Set-test on status word bit: 3 bytes, 9 clocks, PC+3+disp.
// RL5 - Set-test on accumulator bit: 3 bytes, 8 clocks, PC+3+disp.
// RL6 - Set-test on pointer bit: 3 bytes, 10 or 11+n clocks.
// RL7 - Set-test on special register bit: 4 bytes, 11 clocks, PC+4+disp.
// RL8 - Clear-test on short direct bit: 4 bytes, 10/11 clocks, PC+4+disp.
// RL9 - Clear-test on special register bit: 4 bytes, 11 clocks.
// RL10 - Clear-test on status word bit: 4 bytes, 11 clocks.
// RL11 - Test-and-clear short direct bit: 4 bytes, 10/12, clears when set.
// RL12 - Test-and-clear special register bit: 4 bytes, 12 clocks.
// RL13 - Test-and-clear accumulator bit: 3 bytes, 8 clocks.
// RL14 - Test-and-clear status word bit: 4 bytes, 12, flags may change.
// RL15 - Test-and-clear pointer bit: 3 bytes, 10 or 12+n+m clocks.
// RL16 - Loop on B or C: 2 bytes, 6 clocks, decrement then test.
// RL17 - Loop on short direct byte: 3 bytes, 8/10 clocks.
// RL18 - Interrupt enable: 2 bytes, 6 clocks, sets master flag.
// RL19 - Interrupt mask: 2 bytes, 6 clocks, clears master flag.
// RL20 - Displacement is signed, added to next instruction address.
// RL21 - Bank select 2 bytes 4 clocks; idle 1 byte 2 clocks.
// RL22 - Halt and standby: 2 bytes, 6 clocks, enter their modes.
`timescale 1ns/1ns
`default_nettype none
`include "bit_branch_exec_defines.vh"
module bit_branch_cpu_control_exec (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        start,
  input  wire [3:0]  op_code,
  input  wire [2:0]  operand_kind,
  input  wire [2:0]  bit_sel,
  input  wire [7:0]  rel_offset8,
  input  wire [15:0] pc_in,
  input  wire [7:0]  operand_byte,
  input  wire        in_hs_ram,
  input  wire [3:0]  read_waits,
  input  wire [3:0]  write_waits,
  input  wire [1:0]  bank_num,
  input  wire        wake,
  output wire        ready,
  output wire        busy,
  output reg         reject,
  output reg         done,
  output reg         branch_taken,
  output reg  [15:0] next_pc,
  output reg  [2:0]  instr_length,
  output reg  [5:0]  cycle_cost,
  output reg         wr_en,
  output reg  [2:0]  wr_target,
  output reg  [7:0]  wr_data,
  output reg         irq_master_flag,
  output reg  [1:0]  bank_pick_bits,
  output reg         halt_mode,
  output reg         stop_mode
);
  // Run states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_PARK = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;

  // Decoded cost of the offered instruction
  reg  [2:0]  dec_length;
  reg  [5:0]  dec_cycles;
  reg         dec_legal;

  // Evaluation results of the offered instruction
  wire        eval_taken;
  wire        eval_write;
  wire [7:0]  eval_data;
  wire [15:0] eval_fall;
  wire [15:0] eval_target;

  // Held for the length of the instruction
  reg  [3:0]  held_op;
  reg  [2:0]  held_kind;
  reg  [1:0]  held_bank;
  reg         held_taken;
  reg         held_write;
  reg  [7:0]  held_data;
  reg  [15:0] held_pc;
  reg  [2:0]  held_length;
  reg  [5:0]  held_cycles;

  wire        accept;
  wire        expire;

  // Slow-area cost with waits added, capped at the counter width
  function [5:0] slow_cost;
    input [5:0] base;
    input [3:0] n_waits;
    input [3:0] m_waits;
    reg   [6:0] sum;
    begin
      sum = {1'b0, base} + {3'h0, n_waits} + {3'h0, m_waits};
      slow_cost = sum[6] ? 6'h3F : sum[5:0];
    end
  endfunction

  // RL2 area picks figure
  function [5:0] area_cost;
    input       fast;
    input [5:0] fast_cycles;
    input [5:0] slow_cycles;
    begin
      area_cost = fast ? fast_cycles : slow_cycles;
    end
  endfunction

  // Length and cost table
  always @* begin
    dec_length = `LEN_1;
    dec_cycles = `CYC_2;
    dec_legal  = 1'b1;
    case (op_code)
      `OP_BRANCH_IF_BIT_SET: begin
        case (operand_kind)
          `KIND_SADDR: begin
            // RL3 short direct set-test
            dec_length = `LEN_3;
            dec_cycles = area_cost(in_hs_ram, `CYC_8, `CYC_9);
          end
          `KIND_SFR: begin
            // RL7 special register set-test
            dec_length = `LEN_4;
            dec_cycles = `CYC_11;
          end
          `KIND_ACC: begin
            // RL5 accumulator set-test
            dec_length = `LEN_3;
            dec_cycles = `CYC_8;
          end
          `KIND_STATUS_WORD: begin
            // RL4 status word set-test
            dec_length = `LEN_3;
            dec_cycles = `CYC_9;
          end
          `KIND_POINTER: begin
            // RL6 pointer set-test
            dec_length = `LEN_3;
            dec_cycles = area_cost(in_hs_ram, `CYC_10,
                                   slow_cost(`CYC_11, read_waits, 4'h0));
          end
          default: begin
            dec_legal = 1'b0;
          end
        endcase
      end
      `OP_BRANCH_IF_BIT_CLEAR: begin
        case (operand_kind)
          `KIND_SADDR: begin
            // RL8 short direct clear-test
            dec_length = `LEN_4;
            dec_cycles = area_cost(in_hs_ram, `CYC_10, `CYC_11);
          end
          `KIND_SFR: begin
            // RL9 special register clear-test
            dec_length = `LEN_4;
            dec_cycles = `CYC_11;
          end
          `KIND_ACC: begin
            dec_length = `LEN_3;
            dec_cycles = `CYC_8;
          end
          `KIND_STATUS_WORD: begin
            // RL10 four bytes here
            dec_length = `LEN_4;
            dec_cycles = `CYC_11;
          end
          `KIND_POINTER: begin
            dec_length = `LEN_3;
            dec_cycles = area_cost(in_hs_ram, `CYC_10,
                                   slow_cost(`CYC_11, read_waits, 4'h0));
          end
          default: begin
            dec_legal = 1'b0;
          end
        endcase
      end
      `OP_TEST_BRANCH_AND_CLEAR: begin
        case (operand_kind)
          `KIND_SADDR: begin
            // RL11 short direct test-and-clear
            dec_length = `LEN_4;
            dec_cycles = area_cost(in_hs_ram, `CYC_10, `CYC_12);
          end
          `KIND_SFR: begin
            // RL12 special register test-and-clear
            dec_length = `LEN_4;
            dec_cycles = `CYC_12;
          end
          `KIND_ACC: begin
            // RL13 accumulator test-and-clear
            dec_length = `LEN_3;
            dec_cycles = `CYC_8;
          end
          `KIND_STATUS_WORD: begin
            // RL14 status word test-and-clear
            dec_length = `LEN_4;
            dec_cycles = `CYC_12;
          end
          `KIND_POINTER: begin
            // RL15 pointer test-and-clear
            dec_length = `LEN_3;
            dec_cycles = area_cost(in_hs_ram, `CYC_10,
                           slow_cost(`CYC_12, read_waits, write_waits));
          end
          default: begin
            dec_legal = 1'b0;
          end
        endcase
      end
      `OP_DECREMENT_BRANCH_NZ: begin
        case (operand_kind)
          `KIND_REG_B, `KIND_REG_C: begin
            // RL16 register loop cost
            dec_length = `LEN_2;
            dec_cycles = `CYC_6;
          end
          `KIND_SADDR: begin
            // RL17 memory loop cost
            dec_length = `LEN_3;
            dec_cycles = area_cost(in_hs_ram, `CYC_8, `CYC_10);
          end
          default: begin
            dec_legal = 1'b0;
          end
        endcase
      end
      `OP_BANK_SELECT: begin
        // RL21 bank select cost
        dec_length = `LEN_2;
        dec_cycles = `CYC_4;
      end
      `OP_IDLE_INSTR: begin
        // RL21 idle cost
        dec_length = `LEN_1;
        dec_cycles = `CYC_2;
      end
      `OP_IRQ_ENABLE, `OP_IRQ_MASK, `OP_HALT, `OP_STANDBY: begin
        // RL18 control ops cost
        dec_length = `LEN_2;
        dec_cycles = `CYC_6;
      end
      default: begin
        dec_legal = 1'b0;
      end
    endcase
  end

  bit_branch_eval u_eval (
    .op_code          (op_code),
    .bit_sel          (bit_sel),
    .operand_byte     (operand_byte),
    .rel_offset8      (rel_offset8),
    .pc_in            (pc_in),
    .instr_length     (dec_length),
    .branch_taken     (eval_taken),
    .write_back       (eval_write),
    .write_data       (eval_data),
    .fall_through_pc  (eval_fall),
    .branch_target_pc (eval_target)
  );

  // RL1 one clock per cycle
  exec_cycle_timer u_timer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .load    (accept),
    .cycles  (dec_cycles),
    .busy    (busy),
    .expire  (expire)
  );

  // Halted or stopped core takes nothing until woken
  assign ready  = state[0];
  assign accept = ready && start && dec_legal;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (expire) begin
          next_state = (held_op == `OP_HALT || held_op == `OP_STANDBY)
                       ? ST_PARK : ST_IDLE;
        end
      end
      ST_PARK: begin
        if (wake) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_IDLE;
      held_op     <= `OP_IDLE_INSTR;
      held_kind   <= `KIND_SADDR;
      held_bank   <= 2'h0;
      held_taken  <= 1'b0;
      held_write  <= 1'b0;
      held_data   <= 8'h00;
      held_pc     <= 16'h0000;
      held_length <= `LEN_1;
      held_cycles <= `CYC_2;
    end else begin
      state <= next_state;
      if (accept) begin
        held_op     <= op_code;
        held_kind   <= operand_kind;
        held_bank   <= bank_num;
        held_taken  <= eval_taken;
        held_write  <= eval_write;
        held_data   <= eval_data;
        // RL3 taken picks target
        held_pc     <= eval_taken ? eval_target : eval_fall;
        held_length <= dec_length;
        held_cycles <= dec_cycles;
      end
    end
  end

  // Results become visible only once the whole cost has elapsed
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reject          <= 1'b0;
      done            <= 1'b0;
      branch_taken    <= 1'b0;
      next_pc         <= 16'h0000;
      instr_length    <= `LEN_1;
      cycle_cost      <= `CYC_2;
      wr_en           <= 1'b0;
      wr_target       <= `KIND_SADDR;
      wr_data         <= 8'h00;
      irq_master_flag <= 1'b0;
      bank_pick_bits  <= 2'h0;
      halt_mode       <= 1'b0;
      stop_mode       <= 1'b0;
    end else begin
      reject <= ready && start && !dec_legal;
      done   <= expire;
      // RL14 whole byte rewritten
      wr_en  <= expire && held_write;
      if (expire) begin
        branch_taken <= held_taken;
        next_pc      <= held_pc;
        instr_length <= held_length;
        cycle_cost   <= held_cycles;
        wr_target    <= held_kind;
        wr_data      <= held_data;
        case (held_op)
          `OP_IRQ_ENABLE: begin
            // RL18 master flag set
            irq_master_flag <= 1'b1;
          end
          `OP_IRQ_MASK: begin
            // RL19 master flag cleared
            irq_master_flag <= 1'b0;
          end
          `OP_BANK_SELECT: begin
            // RL21 bank bits loaded
            bank_pick_bits <= held_bank;
          end
          `OP_HALT: begin
            // RL22 enter halt
            halt_mode <= 1'b1;
          end
          `OP_STANDBY: begin
            // RL22 enter stop
            stop_mode <= 1'b1;
          end
          default: begin
            halt_mode <= halt_mode;
          end
        endcase
      end else if (state[2] && wake) begin
        halt_mode <= 1'b0;
        stop_mode <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/exec_monitor.sv */
// Concurrent checks on the exec unit ports
`timescale 1ns/1ns
`default_nettype none
module exec_monitor (
  input wire        sys_clk,
  input wire        reset_n,
  input wire        start,
  input wire [15:0] pc_in,
  input wire        wake,
  input wire        ready,
  input wire        busy,
  input wire        done,
  input wire        reject,
  input wire        branch_taken,
  input wire [15:0] next_pc,
  input wire [2:0]  instr_length,
  input wire [5:0]  cycle_cost,
  input wire        wr_en,
  input wire        irq_master_flag,
  input wire [1:0]  bank_pick_bits,
  input wire        halt_mode,
  input wire        stop_mode
);
  reg [5:0]  busy_cnt;
  reg [15:0] pc_q;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt <= 6'h00;
      pc_q     <= 16'h0000;
    end else begin
      busy_cnt <= busy ? busy_cnt + 6'h01 : 6'h00;
      if (start && ready)
        pc_q <= pc_in;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_busy_count:
    assert property (done |-> busy_cnt == cycle_cost)
    else $error("busy length differs from charged cost");
  a_done_follows:
    assert property ($fell(busy) |-> done) else $error("done missing");
  a_done_pulse:
    assert property (done |=> !done) else $error("done too long");
  a_fall_pc:
    assert property (done && !branch_taken |->
      next_pc == pc_q + {13'h0000, instr_length})
    else $error("fall-through address wrong");
  a_wr_done:
    assert property (wr_en |-> done) else $error("write outside done");
  a_irq_change:
    assert property ($changed(irq_master_flag) |-> done)
    else $error("irq flag moved outside done");
  a_bank_change:
    assert property ($changed(bank_pick_bits) |-> done)
    else $error("bank bits moved outside done");
  a_park_ready:
    assert property (halt_mode || stop_mode |-> !ready)
    else $error("ready while parked");
  a_park_hold:
    assert property ((halt_mode || stop_mode) && !wake |=>
      (halt_mode || stop_mode)) else $error("left park without wake");
  a_wake_exit:
    assert property ((halt_mode || stop_mode) && wake |=>
      !halt_mode && !stop_mode) else $error("wake ignored");
  a_accept_resp:
    assert property (start && ready |=> busy != reject)
    else $error("request not answered");
endmodule
bind bit_branch_cpu_control_exec exec_monitor u_exec_monitor (
  .sys_clk, .reset_n, .start, .pc_in, .wake, .ready, .busy, .done,
  .reject, .branch_taken, .next_pc, .instr_length, .cycle_cost, .wr_en,
  .irq_master_flag, .bank_pick_bits, .halt_mode, .stop_mode);
`default_nettype wire

/* File: bench/exec_mem_model.sv */
// Operand store standing in for RAM, special registers and memory
`timescale 1ns/1ns
`default_nettype none
module exec_mem_model (
  input  wire       sys_clk,
  input  wire [2:0] operand_kind,
  input  wire       wr_en,
  input  wire [2:0] wr_target,
  input  wire [7:0] wr_data,
  input  wire       ld_en,
  input  wire [7:0] ld_data,
  output wire [7:0] operand_byte
);
  logic [7:0] mem [0:7];
  // Forward write-back so a back-to-back request sees the new byte
  assign operand_byte = (wr_en && wr_target == operand_kind) ?
                        wr_data : mem[operand_kind];
  always @(posedge sys_clk) begin
    if (wr_en)
      mem[wr_target] <= wr_data;
    if (ld_en)
      mem[operand_kind] <= ld_data;
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the bit-branch exec unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        sys_clk, reset_n, start, in_hs_ram, wake, ld_en;
  logic [3:0]  op_code, read_waits, write_waits;
  logic [2:0]  operand_kind, bit_sel;
  logic [7:0]  rel_offset8, ld_data, e_wd;
  logic [15:0] pc_in, e_pc;
  logic [1:0]  bank_num;
  logic [5:0]  e_cost;
  logic [2:0]  e_len;
  logic        e_tk, e_we;
  logic [7:0]  bmem [0:7];
  wire         ready, busy, reject, done, branch_taken, wr_en;
  wire         irq_master_flag, halt_mode, stop_mode;
  wire [15:0]  next_pc;
  wire [2:0]   instr_length, wr_target;
  wire [5:0]   cycle_cost;
  wire [7:0]   wr_data, operand_byte;
  wire [1:0]   bank_pick_bits;
  integer      num_errors, checked, seed, i, j, h;
  bit_branch_cpu_control_exec u_bit_branch_cpu_control_exec (
    .sys_clk, .reset_n, .start, .op_code, .operand_kind, .bit_sel,
    .rel_offset8, .pc_in, .operand_byte, .in_hs_ram, .read_waits,
    .write_waits, .bank_num, .wake, .ready, .busy, .reject, .done,
    .branch_taken, .next_pc, .instr_length, .cycle_cost, .wr_en,
    .wr_target, .wr_data, .irq_master_flag, .bank_pick_bits,
    .halt_mode, .stop_mode);
  exec_mem_model u_exec_mem_model (.sys_clk, .operand_kind, .wr_en,
    .wr_target, .wr_data, .ld_en, .ld_data, .operand_byte);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked = checked + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task ld(input [2:0] k, input [7:0] v);
    operand_kind = k;
    ld_data = v;
    ld_en = 1'b1;
    @(negedge sys_clk);
    ld_en = 1'b0;
    bmem[k] = v;
  endtask
  task model(input [3:0] op, input [2:0] k, input [2:0] b, input [7:0] d,
             input [15:0] pc, input hs, input [3:0] n, input [3:0] m);
    logic [7:0] v;
    v = bmem[k];
    e_tk = 1'b0;
    e_we = 1'b0;
    e_len = 3'h2;
    e_cost = 6'h06;
    if (op < 4'h3) begin
      e_tk = v[b] ^ (op == 4'h1);
      e_len = (k == 3'h2 || k == 3'h4) ? 3'h3 : 3'h4;
      if (op == 4'h0 && k != 3'h1)
        e_len = 3'h3;
      case (k)
        3'h0: e_cost = hs ? (op == 4'h0 ? 6'h08 : 6'h0A) :
                       (op == 4'h0 ? 6'h09 : (op == 4'h1 ? 6'h0B : 6'h0C));
        3'h1: e_cost = op == 4'h2 ? 6'h0C : 6'h0B;
        3'h2: e_cost = 6'h08;
        3'h3: e_cost = op == 4'h0 ? 6'h09 : (op == 4'h1 ? 6'h0B : 6'h0C);
        default: e_cost = hs ? 6'h0A : (op == 4'h2 ?
                          6'h0C + n + m : 6'h0B + n);
      endcase
      e_we = op == 4'h2 && e_tk;
      e_wd = v & ~(8'h01 << b);
    end else if (op == 4'h3) begin
      e_wd = v - 8'h01;
      e_tk = e_wd != 8'h00;
      e_we = 1'b1;
      e_len = k == 3'h0 ? 3'h3 : 3'h2;
      e_cost = k == 3'h0 ? (hs ? 6'h08 : 6'h0A) : 6'h06;
    end else if (op == 4'h4) begin
      e_cost = 6'h04;
    end else if (op == 4'h5) begin
      e_len = 3'h1;
      e_cost = 6'h02;
    end
    e_pc = pc + e_len + (e_tk ? {{8{d[7]}}, d} : 16'h0000);
  endtask
  task run(input [3:0] op, input [2:0] k, input [2:0] b, input [7:0] d,
           input [15:0] pc, input hs, input [3:0] n, input [3:0] m);
    integer c;
    model(op, k, b, d, pc, hs, n, m);
    op_code = op;
    operand_kind = k;
    bit_sel = b;
    rel_offset8 = d;
    pc_in = pc;
    in_hs_ram = hs;
    read_waits = n;
    write_waits = m;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    c = 1;
    while (done !== 1'b1 && c < 80) begin
      @(negedge sys_clk);
      c = c + 1;
    end
    chk("latency", c, e_cost + 1);
    chk("taken", branch_taken, e_tk);
    chk("next_pc", next_pc, e_pc);
    chk("length", instr_length, e_len);
    chk("cost", cycle_cost, e_cost);
    chk("wr_en", wr_en, e_we);
    if (e_we) begin
      chk("wr_data", wr_data, e_wd);
      chk("wr_target", wr_target, k);
      bmem[k] = e_wd;
    end
  endtask
  initial begin
    #800000;
    num_errors = num_errors + 1;
    finish_test;
  end
  initial begin
    seed = 32'h83b1e504;
    num_errors = 0;
    checked = 0;
    {reset_n, start, in_hs_ram, wake, ld_en} = 5'h00;
    {op_code, read_waits, write_waits, bank_num} = 14'h0000;
    {operand_kind, bit_sel, rel_offset8, ld_data, pc_in} = 38'h0;
    repeat (5) @(negedge sys_clk);
    reset_n = 1'b1;
    chk("rst_len", instr_length, 3'h1);
    chk("rst_cost", cycle_cost, 6'h02);
    chk("rst_ready", ready, 1'b1);
    chk("rst_pc", next_pc, 16'h0000);
    $display("test reset done");
    for (i = 0; i < 3; i = i + 1)
      for (j = 0; j < 5; j = j + 1)
        for (h = 0; h < 4; h = h + 1) begin
          ld(j, $random(seed));
          run(i, j, $random(seed), $random(seed), $random(seed), h[0],
              $random(seed), $random(seed));
        end
    // Cleared bit must be seen by the very next request
    ld(3'h0, 8'hFF);
    run(4'h2, 3'h0, 3'h3, 8'h80, 16'hFFF0, 1'b1, 4'h0, 4'h0);
    run(4'h0, 3'h0, 3'h3, 8'h7F, 16'hFFFE, 1'b1, 4'h0, 4'h0);
    $display("test bit branches done");
    ld(3'h5, 8'h02);
    run(4'h3, 3'h5, 3'h0, 8'hFE, 16'h1000, 1'b1, 4'h0, 4'h0);
    run(4'h3, 3'h5, 3'h0, 8'hFE, 16'h1000, 1'b1, 4'h0, 4'h0);
    ld(3'h6, $random(seed));
    run(4'h3, 3'h6, 3'h0, $random(seed), $random(seed), 1'b1, 4'h0, 4'h0);
    for (h = 0; h < 2; h = h + 1) begin
      ld(3'h0, h ? $random(seed) : 8'h01);
      run(4'h3, 3'h0, 3'h0, $random(seed), $random(seed), h[0], 4'h0, 4'h0);
    end
    $display("test loops done");
    for (i = 4; i < 8; i = i + 1) begin
      bank_num = $random(seed);
      run(i, 3'h0, 3'h0, 8'h00, $random(seed), 1'b1, 4'h0, 4'h0);
      if (i == 4)
        chk("bank", bank_pick_bits, bank_num);
      if (i > 5)
        chk("irq", irq_master_flag, i == 6);
    end
    for (i = 8; i < 10; i = i + 1) begin
      run(i, 3'h0, 3'h0, 8'h00, 16'h2000, 1'b1, 4'h0, 4'h0);
      chk("park", {halt_mode, stop_mode}, i == 8 ? 2'h2 : 2'h1);
      chk("park_ready", ready, 1'b0);
      op_code = 4'h5;
      start = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk("park_busy", busy, 1'b0);
      start = 1'b0;
      wake = 1'b1;
      @(negedge sys_clk);
      wake = 1'b0;
      chk("unpark", {halt_mode, stop_mode}, 2'h0);
      @(negedge sys_clk);
      chk("unpark_ready", ready, 1'b1);
    end
    $display("test control done");
    op_code = 4'h3;
    operand_kind = 3'h1;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    chk("reject", reject, 1'b1);
    chk("reject_busy", busy, 1'b0);
    op_code = 4'h8;
    operand_kind = 3'h0;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    reset_n = 1'b0;
    @(negedge sys_clk);
    chk("rst_busy", busy, 1'b0);
    chk("rst_halt", halt_mode, 1'b0);
    reset_n = 1'b1;
    @(negedge sys_clk);
    $display("test reject and reset done");
    finish_test;
  end
endmodule
`default_nettype wire
